// ==== common/sync_check_pkg.sv ====
// Constants, field layout and types of the sync check voltage window.
// Voltages are magnitudes in units of 0.01 V secondary.
package sync_check_pkg;

  localparam int ADDR_W  = 5;
  localparam int V_W     = 16;
  localparam int RCF_W   = 8;
  localparam int PROD_W  = 24;
  localparam int DEG_W   = 9;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_RCF  = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_VLO  = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_VHI  = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_STAT = 5'h10;

  // Control field positions
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_DELTA_BIT = 1;
  localparam int CTRL_SEL_LSB   = 4;
  localparam int CTRL_ANG_LSB   = 8;

  // Setting limits, in hundredths; ANG_MAX counts 30 degree steps
  localparam int RCF_MIN   = 50;
  localparam int RCF_MAX   = 200;
  localparam int V_MAX     = 30000;
  localparam int ANG_MAX   = 11;

  localparam logic [RCF_W-1:0] RCF_RST   = 8'h64;
  localparam logic [RCF_W-1:0] RCF_UNITY = 8'h64;
  localparam logic [V_W-1:0]   VLO_RST   = 16'h0000;
  localparam logic [V_W-1:0]   VHI_RST   = 16'h0000;
  localparam logic [DEG_W-1:0] ANG_STEP  = 9'h01e;
  localparam logic [7:0]       THR_SCALE = 8'h64;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // A/B/C name AB/BC/CA on a delta connection
  typedef enum logic [1:0] {
    SEL_PH_A,
    SEL_PH_B,
    SEL_PH_C,
    SEL_ANGLE
  } phase_sel_t;

endpackage

// ==== common/phase_sel_if.sv ====
// Carries the phase selection and the measured phase voltages.
// Joined between the top module and its phase selector.
`timescale 1ns/100ps
interface phase_sel_if;
  import sync_check_pkg::*;
  phase_sel_t     sel;
  logic [V_W-1:0] va;
  logic [V_W-1:0] vb;
  logic [V_W-1:0] vc;
  logic [V_W-1:0] v_phase;
  logic [V_W-1:0] v_ref;

  modport ctl (output sel, va, vb, vc, input v_phase, v_ref);
  modport sel_side (input sel, va, vb, vc, output v_phase, v_ref);
endinterface

// ==== verilog/phase_select.sv ====
// Routes the phase-side and reference voltages from the selector.
// Purely combinational; the caller registers the results.
`timescale 1ns/100ps
module phase_select
(
  phase_sel_if.sel_side ps
);
  import sync_check_pkg::*;

  // Frequency reference is always the A (or AB) input
  assign ps.v_ref = ps.va;

  always_comb
  begin
    case (ps.sel)
      SEL_PH_B: ps.v_phase = ps.vb;
      SEL_PH_C: ps.v_phase = ps.vc;
      SEL_ANGLE: ps.v_phase = ps.va;
      default: ps.v_phase = ps.va;
    endcase
  end
endmodule

// ==== verilog/window_cmp.sv ====
// Healthy-voltage window on a scaled magnitude.
// Thresholds arrive already multiplied by the gain's unity value.
`timescale 1ns/100ps
module window_cmp
  #(parameter int V_W    = 16,
    parameter int G_W    = 8,
    parameter int PROD_W = 24)
(
  input  wire logic [V_W-1:0]    volt,
  input  wire logic [G_W-1:0]    gain,
  input  wire logic [PROD_W-1:0] lo_scaled,
  input  wire logic [PROD_W-1:0] hi_scaled,
  output logic                   in_window
);
  logic [PROD_W-1:0] prod;

  // Correction by multiplication avoids dividing the thresholds
  assign prod = PROD_W'(volt) * PROD_W'(gain);
  // Both bounds exclusive
  assign in_window = (prod > lo_scaled) && (prod < hi_scaled);
endmodule

// ==== verilog/sync_check_voltage_window.sv ====
// Sync check voltage window: AXI4-Lite settings, phase selection,
// ratio correction and the three healthy-voltage flags.
// Assumes one-cycle meas_valid with magnitudes in 0.01 V units.
`timescale 1ns/100ps
module sync_check_voltage_window
(
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire logic [sync_check_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [sync_check_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [31:0]                          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  input  wire logic                            meas_valid,
  input  wire logic [sync_check_pkg::V_W-1:0]  va,
  input  wire logic [sync_check_pkg::V_W-1:0]  vb,
  input  wire logic [sync_check_pkg::V_W-1:0]  vc,
  input  wire logic [sync_check_pkg::V_W-1:0]  vs,
  output logic                                 reference_healthy,
  output logic                                 phase_side_healthy,
  output logic                                 sync_input_healthy,
  output logic                                 result_strobe,
  output logic [sync_check_pkg::V_W-1:0]       ref_freq_voltage,
  output logic [sync_check_pkg::V_W-1:0]       sync_freq_voltage,
  output logic [sync_check_pkg::V_W-1:0]       phase_side_voltage,
  output logic [sync_check_pkg::DEG_W-1:0]     angle_lag_deg,
  output logic                                 transformer_connection_type
);
  import sync_check_pkg::*;

  logic              en_ff;
  logic              delta_ff;
  phase_sel_t        sel_ff;
  logic [3:0]        ang_ff;
  logic [RCF_W-1:0]  rcf_ff;
  logic [V_W-1:0]    vlo_ff;
  logic [V_W-1:0]    vhi_ff;
  logic [2:0]        flags_ff;
  logic              strobe_ff;
  logic [V_W-1:0]    ref_v_ff;
  logic [V_W-1:0]    sync_v_ff;
  logic [V_W-1:0]    ph_v_ff;
  logic [DEG_W-1:0]  lag_ff;

  logic              awready_ff;
  logic              wready_ff;
  logic              aw_got_ff;
  logic              w_got_ff;
  logic [ADDR_W-1:0] waddr_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              arready_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;

  logic              aw_hs;
  logic              w_hs;
  logic              ar_hs;
  logic              do_write;
  logic              nxt_aw_got;
  logic              nxt_w_got;
  logic [31:0]       merged;
  logic [2:0]        win;
  logic [PROD_W-1:0] lo_scaled;
  logic [PROD_W-1:0] hi_scaled;
  logic [V_W-1:0]    volt [3];
  logic [RCF_W-1:0]  gain [3];

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    return (a == OFS_CTRL) || (a == OFS_RCF) || (a == OFS_VLO) ||
           (a == OFS_VHI) || (a == OFS_STAT);
  endfunction

  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
    logic [31:0] w;
    w = 32'h0;
    case (a)
      OFS_CTRL:
      begin
        w[CTRL_EN_BIT]         = en_ff;
        w[CTRL_DELTA_BIT]      = delta_ff;
        w[CTRL_SEL_LSB +: 2]   = sel_ff;
        w[CTRL_ANG_LSB +: 4]   = ang_ff;
      end
      OFS_RCF:  w[RCF_W-1:0] = rcf_ff;
      OFS_VLO:  w[V_W-1:0]   = vlo_ff;
      OFS_VHI:  w[V_W-1:0]   = vhi_ff;
      OFS_STAT: w[2:0]       = flags_ff;
      default:  w = 32'h0;
    endcase
    return w;
  endfunction

  // AXI write channels are taken independently, answered when both held
  assign aw_hs      = s_axi_awvalid & awready_ff;
  assign w_hs       = s_axi_wvalid & wready_ff;
  assign do_write   = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign nxt_aw_got = aw_hs | (aw_got_ff & ~do_write);
  assign nxt_w_got  = w_hs | (w_got_ff & ~do_write);

  always_comb
  begin
    merged = read_word(waddr_ff);
    for (int i = 0; i < 4; i++)
    begin
      if (wstrb_ff[i])
        merged[8*i +: 8] = wdata_ff[8*i +: 8];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      waddr_ff   <= '0;
      wdata_ff   <= 32'h0;
      wstrb_ff   <= 4'h0;
    end
    else
    begin
      aw_got_ff  <= nxt_aw_got;
      w_got_ff   <= nxt_w_got;
      awready_ff <= ~nxt_aw_got;
      wready_ff  <= ~nxt_w_got;
      if (aw_hs)
        waddr_ff <= s_axi_awaddr;
      if (w_hs)
      begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= addr_ok(waddr_ff) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0;
      rresp_ff   <= RESP_OKAY;
    end
    else
    begin
      arready_ff <= ~(ar_hs | (rvalid_ff & ~s_axi_rready));
      if (ar_hs)
      begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= read_word(s_axi_araddr);
        rresp_ff  <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_ff <= 1'b0;
    end
  end
  assign ar_hs = s_axi_arvalid & arready_ff;

  // Settings; out-of-range values are dropped and the old one kept
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_ff    <= 1'b0;
      delta_ff <= 1'b0;
      sel_ff   <= SEL_PH_A;
      ang_ff   <= 4'h0;
      rcf_ff   <= RCF_RST;
      vlo_ff   <= VLO_RST;
      vhi_ff   <= VHI_RST;
    end
    else if (do_write)
    begin
      case (waddr_ff)
        OFS_CTRL:
        begin
          en_ff    <= merged[CTRL_EN_BIT];
          delta_ff <= merged[CTRL_DELTA_BIT];
          sel_ff   <= phase_sel_t'(merged[CTRL_SEL_LSB +: 2]);
          if (32'(merged[CTRL_ANG_LSB +: 4]) <= ANG_MAX)
            ang_ff <= merged[CTRL_ANG_LSB +: 4];
        end
        OFS_RCF:
          if (merged >= RCF_MIN && merged <= RCF_MAX)
            rcf_ff <= merged[RCF_W-1:0];
        OFS_VLO:
          if (merged <= V_MAX)
            vlo_ff <= merged[V_W-1:0];
        OFS_VHI:
          if (merged <= V_MAX)
            vhi_ff <= merged[V_W-1:0];
        default: ;
      endcase
    end
  end

  phase_sel_if ps ();
  assign ps.sel = sel_ff;
  assign ps.va  = va;
  assign ps.vb  = vb;
  assign ps.vc  = vc;

  phase_select u_phase_select
  (
    .ps (ps.sel_side)
  );

  // Shared thresholds; no transformer ratio or nominal setting enters
  assign lo_scaled = PROD_W'(vlo_ff) * PROD_W'(THR_SCALE);
  assign hi_scaled = PROD_W'(vhi_ff) * PROD_W'(THR_SCALE);

  // Channel 0 reference, 1 phase side, 2 sync input
  assign volt[0] = ps.v_ref;
  assign gain[0] = rcf_ff;
  assign volt[1] = ps.v_phase;
  assign gain[1] = rcf_ff;
  assign volt[2] = vs;
  assign gain[2] = RCF_UNITY;

  for (genvar g = 0; g < 3; g++)
  begin : g_win
    window_cmp #(.V_W(V_W), .G_W(RCF_W), .PROD_W(PROD_W)) u_win
    (
      .volt      (volt[g]),
      .gain      (gain[g]),
      .lo_scaled (lo_scaled),
      .hi_scaled (hi_scaled),
      .in_window (win[g])
    );
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !en_ff)
    begin
      flags_ff  <= 3'h0;
      strobe_ff <= 1'b0;
    end
    else
    begin
      strobe_ff <= meas_valid;
      if (meas_valid)
        flags_ff <= win;
    end
  end

  // Raw voltages onward; the corrected value never leaves this block
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !en_ff)
    begin
      ref_v_ff  <= '0;
      sync_v_ff <= '0;
      ph_v_ff   <= '0;
      lag_ff    <= '0;
    end
    else
    begin
      if (meas_valid)
      begin
        ref_v_ff  <= ps.v_ref;
        sync_v_ff <= vs;
        ph_v_ff   <= ps.v_phase;
      end
      lag_ff <= (sel_ff == SEL_ANGLE) ? {5'h0, ang_ff} * ANG_STEP : '0;
    end
  end

  assign s_axi_awready      = awready_ff;
  assign s_axi_wready       = wready_ff;
  assign s_axi_bvalid       = bvalid_ff;
  assign s_axi_bresp        = bresp_ff;
  assign s_axi_arready      = arready_ff;
  assign s_axi_rvalid       = rvalid_ff;
  assign s_axi_rdata        = rdata_ff;
  assign s_axi_rresp        = rresp_ff;
  assign reference_healthy  = flags_ff[0];
  assign phase_side_healthy = flags_ff[1];
  assign sync_input_healthy = flags_ff[2];
  assign result_strobe      = strobe_ff;
  assign ref_freq_voltage   = ref_v_ff;
  assign sync_freq_voltage  = sync_v_ff;
  assign phase_side_voltage = ph_v_ff;
  assign angle_lag_deg      = lag_ff;
  assign transformer_connection_type = delta_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_disabled_quiet: assert property (!en_ff |=> flags_ff == 3'h0 &&
    !strobe_ff) else $error("flags active while disabled");
  a_named_route: assert property (en_ff && meas_valid &&
    sel_ff == SEL_PH_C |=> phase_side_voltage == $past(vc))
    else $error("named phase not routed");
  a_angle_route: assert property (en_ff && meas_valid &&
    sel_ff == SEL_ANGLE |=> phase_side_voltage == $past(va))
    else $error("numeric selector not on A input");
  a_freq_sources: assert property (en_ff && meas_valid |=>
    ref_freq_voltage == $past(va) && sync_freq_voltage == $past(vs))
    else $error("frequency source wrong");
  a_angle_steps: assert property (en_ff && sel_ff == SEL_ANGLE &&
    $stable(ang_ff) |=> angle_lag_deg == 30 * $past(ang_ff) &&
    $past(ang_ff) <= 11) else $error("angle lag not in 30 degree steps");
  a_rcf_range: assert property (rcf_ff >= 50 && rcf_ff <= 200)
    else $error("correction factor out of range");
  a_sync_window: assert property (en_ff && meas_valid &&
    vs * 100 > vlo_ff * 100 && vs * 100 < vhi_ff * 100
    |=> sync_input_healthy) else $error("sync flag missing");
  a_phase_ref_tie: assert property (en_ff && meas_valid &&
    (sel_ff == SEL_PH_A || sel_ff == SEL_ANGLE)
    |=> phase_side_healthy == reference_healthy)
    else $error("phase and reference flags differ");
  a_corrected_b: assert property (en_ff && meas_valid &&
    sel_ff == SEL_PH_B && vb * rcf_ff > vlo_ff * 100 &&
    vb * rcf_ff < vhi_ff * 100 |=> phase_side_healthy)
    else $error("corrected B not healthy");
  a_ref_window: assert property (en_ff && meas_valid &&
    !(va * rcf_ff > vlo_ff * 100 && va * rcf_ff < vhi_ff * 100)
    |=> !reference_healthy) else $error("reference flag wrongly set");
  a_thr_range: assert property (vlo_ff <= 30000 && vhi_ff <= 30000)
    else $error("threshold out of range");
  a_edge_excl: assert property (en_ff && meas_valid &&
    vs == vlo_ff |=> !sync_input_healthy ##1 1)
    else $error("low bound not exclusive");

  c_all_healthy: cover property (en_ff && meas_valid ##1 flags_ff == 3'h7);
  c_angle_mode: cover property (sel_ff == SEL_ANGLE && angle_lag_deg != 0);
  c_write_read: cover property (do_write ##[1:8] ar_hs);
endmodule

// ==== verification/meas_source.sv ====
// Measurement source standing in for the voltage front end.
// Drives one-cycle measurement strobes; between strobes the
// magnitude lines carry inverted junk so stale values never pass.
`timescale 1ns/100ps
module meas_source
(
  input  wire logic        aclk,
  output logic             meas_valid,
  output logic [15:0]      va,
  output logic [15:0]      vb,
  output logic [15:0]      vc,
  output logic [15:0]      vs
);
  initial
  begin
    meas_valid = 1'b0;
    va = 16'h0000;
    vb = 16'h0000;
    vc = 16'h0000;
    vs = 16'h0000;
  end

  // One measurement, valid for exactly one cycle
  task automatic send(input logic [15:0] a, b, c, s);
    @(posedge aclk);
    meas_valid <= 1'b1;
    va <= a;
    vb <= b;
    vc <= c;
    vs <= s;
    @(posedge aclk);
    meas_valid <= 1'b0;
    va <= ~a;
    vb <= ~b;
    vc <= ~c;
    vs <= ~s;
  endtask
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the sync check voltage window.
// Drives settings over AXI4-Lite and measurements via meas_source.
`timescale 1ns/100ps
module testbench;
  import sync_check_pkg::*;
  logic aclk, aresetn;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, meas_valid;
  logic [V_W-1:0] va, vb, vc, vs, ref_v, sync_v, ph_v;
  logic ref_h, ph_h, sync_h, strobe, conn;
  logic [DEG_W-1:0] lag;
  logic [31:0] rd;
  logic [1:0] rr;
  int fails, tests_run, k;
  int lo, hi, rcf, sel, dl, a, b, c, s;
  int bnd[4] = '{14965, 14966, 18290, 18291};

  sync_check_voltage_window sync_check_voltage_window_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .meas_valid(meas_valid), .va(va), .vb(vb), .vc(vc), .vs(vs),
    .reference_healthy(ref_h), .phase_side_healthy(ph_h),
    .sync_input_healthy(sync_h), .result_strobe(strobe),
    .ref_freq_voltage(ref_v), .sync_freq_voltage(sync_v),
    .phase_side_voltage(ph_v), .angle_lag_deg(lag),
    .transformer_connection_type(conn));

  meas_source meas_source_i (.aclk(aclk), .meas_valid(meas_valid),
    .va(va), .vb(vb), .vc(vc), .vs(vs));

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Write with address and data offered together; waits for bvalid
  // Response ready stays high afterwards, so calls chain cleanly
  task automatic wr(input logic [ADDR_W-1:0] ad, input int d);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        rr = s_axi_bresp;
        break;
      end
    end
  endtask

  task automatic rdr(input logic [ADDR_W-1:0] ad);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        break;
      end
    end
  endtask

  function automatic logic hf(input int v, g);
    return (v * g > lo * 100) && (v * g < hi * 100);
  endfunction

  // One measurement, results expected as with the function enabled or disabled per en; flags checked on result
  task automatic meas(input int en);
    logic er, ep, es;
    int pv;
    pv = (sel == 1) ? b : (sel == 2) ? c : a;
    meas_source_i.send(a[15:0], b[15:0], c[15:0], s[15:0]);
    #1;
    er = en && hf(a, rcf);
    ep = en && hf(pv, rcf);
    es = en && hf(s, 100);
    chk("strobe", strobe, en);
    chk("ref flag", ref_h, er);
    chk("phase flag", ph_h, ep);
    chk("sync flag", sync_h, es);
    chk("ref volt", ref_v, en ? a : 0);
    chk("sync volt", sync_v, en ? s : 0);
    chk("phase volt", ph_v, en ? pv : 0);
    @(posedge aclk);
    #1;
    chk("strobe end", strobe, 1'b0);
    rdr(OFS_STAT);
    chk("status", rd[2:0], {es, ep, er});
    #1;
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    finish_test;
  end

  initial
  begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    lo = 0;
    hi = 0;
    rcf = 100;
    sel = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(OFS_CTRL);
    chk("ctrl rst", rd, 32'h0000_0000);
    rdr(OFS_RCF);
    chk("rcf rst", rd, {24'h0, RCF_RST});
    rdr(OFS_VHI);
    chk("vhi rst", rd, {16'h0, VHI_RST});
    rdr(5'h14);
    chk("unmapped resp", rr, RESP_SLVERR);
    chk("unmapped data", rd, 32'h0000_0000);
    wr(5'h14, 1);
    chk("unmapped wr resp", rr, RESP_SLVERR);
    a = 12000; b = 10000; c = 13000; s = 16628;
    meas(0);
    wr(OFS_VLO, 14965);
    wr(OFS_VHI, 18291);
    wr(OFS_RCF, 139);
    lo = 14965; hi = 18291; rcf = 139;
    wr(OFS_RCF, 49);
    chk("rcf low resp", rr, RESP_OKAY);
    wr(OFS_RCF, 201);
    rdr(OFS_RCF);
    chk("rcf range", rd, 32'd139);
    wr(OFS_VLO, 30001);
    rdr(OFS_VLO);
    chk("vlo range", rd, 32'd14965);
    wr(OFS_STAT, 7);
    chk("stat wr resp", rr, RESP_OKAY);
    for (k = 0; k < 8; k++)
    begin
      sel = k % 4;
      dl = k / 4;
      a = (k == 7) ? 14000 : 12000;
      b = (k == 5) ? 12500 : 10000;
      wr(OFS_CTRL, 1 | (dl << 1) | (sel << 4) | (3 << 8));
      meas(1);
      chk("lag", lag, sel == 3 ? 90 : 0);
      chk("delta", conn, dl[0]);
    end
    sel = 0;
    a = 12000;
    for (k = 0; k < 4; k++)
    begin
      s = bnd[k];
      meas(1);
    end
    for (k = 0; k < 13; k++)
    begin
      wr(OFS_CTRL, 1 | (3 << 4) | (k << 8));
      repeat (2) @(posedge aclk);
      #1;
      chk("angle", lag, k < 12 ? 30 * k : 330);
    end
    wr(OFS_CTRL, 0);
    repeat (2) @(posedge aclk);
    #1;
    chk("lag off", lag, 0);
    meas(0);
    finish_test;
  end
endmodule
